// file: verilog/tsr_regs.sv
// Status and control register bank of the multichannel converter module.
// Assumes acquisition state from same-clock logic; switches arrive as pins.
`default_nettype none

module tsr_regs #(
  parameter int NCHIP = 4,
  parameter logic [7:0] FW_REVISION = 8'h12 // Arbitrary value
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register access
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic acc_iack,
  input wire logic [31:0] acc_addr,
  input wire logic [31:0] acc_wdata,
  output logic acc_ack,
  output logic [31:0] acc_rdata,
  // Board switches (pins)
  input wire logic [15:0] rotary_base,
  input wire logic term_switch,
  // Acquisition state
  input wire tsr_pkg::tsr_acq_t acq,
  input wire logic [NCHIP-1:0] chip_error,
  input wire logic bus_fault_event,
  input wire logic trigger_drop_event,
  input wire logic ext_trigger,
  input wire logic chain_active,
  input wire logic chain_all_sent,
  input wire logic chain_end_berr,
  // Control outputs
  output tsr_pkg::tsr_strobe_t strobes,
  output logic irq_req,
  output logic [2:0] irq_level,
  output logic term_enable,
  output logic [4:0] slot_number,
  output logic [7:0] bcast_base,
  output logic [1:0] bcast_ctl,
  output logic [15:0] buffer_warn_level,
  output logic [7:0] block_event_count
);

  // ************************************************************
  // Synchronisers for board switches
  // ************************************************************
  logic [15:0] rot_meta_ff;
  logic [15:0] rot_ff;
  logic term_meta_ff;
  logic term_ff;

  always_ff @(posedge sys_clk) begin
    rot_meta_ff <= rotary_base;
    rot_ff <= rot_meta_ff;
    term_meta_ff <= term_switch;
    term_ff <= term_meta_ff;
  end

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0] reloc_hi_ff;
  logic [7:0] reloc_lo_ff;
  logic reloc_en_ff;
  logic [2:0] irq_level_ff;
  logic [7:0] irq_vector_ff;
  logic [4:0] slot_ff;
  logic [7:0] bcast_ff;
  logic [1:0] bcast_ctl_ff;
  logic [15:0] warn_ff;
  logic [7:0] blt_ff;
  logic [31:0] trig_cnt_ff;
  logic berr_ff;
  logic trglost_ff;
  logic chain_done_ff;
  logic [15:0] status_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  tsr_pkg::tsr_strobe_t strobe_ff;
  logic irq_ff;
  logic term_en_ff;

  // Module reset restarts every register except the strobes, the bus answer and the switch synchronisers
  wire logic rst_all = reset | strobe_ff.module_reset;

  // ************************************************************
  // Address decode
  // ************************************************************
  wire logic [15:0] base_sel = reloc_en_ff ? {reloc_hi_ff, reloc_lo_ff} : rot_ff;
  wire logic base_hit = acc_req & ~acc_iack & (acc_addr[31:16] == base_sel);
  wire logic [15:0] off = acc_addr[15:0];
  wire logic wr = base_hit & acc_write;
  wire logic rd = base_hit & ~acc_write;
  wire logic w_reloc_hi = wr & (off == tsr_pkg::OFF_RELOC_HIGH);
  wire logic w_reloc_lo = wr & (off == tsr_pkg::OFF_RELOC_LOW);
  wire logic w_reloc_en = wr & (off == tsr_pkg::OFF_RELOC_EN);
  wire logic w_level = wr & (off == tsr_pkg::OFF_IRQ_LEVEL);
  wire logic w_vector = wr & (off == tsr_pkg::OFF_IRQ_VECTOR);
  wire logic w_slot = wr & (off == tsr_pkg::OFF_SLOT);
  wire logic w_bcast = wr & (off == tsr_pkg::OFF_BCAST_BASE);
  wire logic w_bctl = wr & (off == tsr_pkg::OFF_BCAST_CTL);
  wire logic hit_mod_reset = base_hit & (off == tsr_pkg::OFF_MOD_RESET);
  wire logic w_clear = wr & (off == tsr_pkg::OFF_SOFT_CLEAR);
  wire logic w_evrst = wr & (off == tsr_pkg::OFF_SOFT_EVRST);
  wire logic w_trig = wr & (off == tsr_pkg::OFF_SOFT_TRIG);
  wire logic w_warn = wr & (off == tsr_pkg::OFF_WARN_LEVEL);
  wire logic w_blt = wr & (off == tsr_pkg::OFF_BLOCK_EVENTS);
  wire logic r_status = rd & (off == tsr_pkg::OFF_STATUS);

  // Every printed location answers; unmapped offsets stay silent so the master times out
  wire logic mapped = (off >= tsr_pkg::OFF_STATUS) & (off <= tsr_pkg::OFF_FW_VERSION)
                      & ~off[0] & (off != tsr_pkg::OFF_TRIG_COUNT + 16'h0002);

  // ************************************************************
  // Status word
  // ************************************************************
  wire logic output_data_available = acq.window_select_mode ? (acq.events_held != 16'h0000)
                                             : (acq.buf_words != 16'h0000);
  wire logic almost = acq.buf_words >= warn_ff;
  wire logic full = acq.buf_words >= tsr_pkg::FULL_WORDS;
  wire logic term_on = acq.term_soft_sel ? acq.term_soft_on : term_ff;
  wire logic [3:0] err4 = 4'(chip_error);
  wire logic purged_now = (acq.buf_words == 16'h0000) | chain_done_ff;
  wire logic [15:0] nxt_status = {trglost_ff, acq.pair_mode, acq.resolution_code,
                                  purged_now, berr_ff, err4, term_on, acq.header_en,
                                  acq.window_select_mode, full, almost,
                                  output_data_available};

  // Warn level held inside its legal range
  wire logic [15:0] warn_wr = acc_wdata[15:0];
  wire logic [15:0] nxt_warn = (warn_wr < tsr_pkg::WARN_MIN) ? tsr_pkg::WARN_MIN :
                               (warn_wr > tsr_pkg::WARN_MAX) ? tsr_pkg::WARN_MAX : warn_wr;

  // ************************************************************
  // Read selection
  // ************************************************************
  wire logic [31:0] rd_mux =
    (off == tsr_pkg::OFF_STATUS) ? {16'h0000, status_ff} :
    (off == tsr_pkg::OFF_RELOC_HIGH) ? {24'h000000, reloc_hi_ff} :
    (off == tsr_pkg::OFF_RELOC_LOW) ? {24'h000000, reloc_lo_ff} :
    (off == tsr_pkg::OFF_IRQ_LEVEL) ? {29'h00000000, irq_level_ff} :
    (off == tsr_pkg::OFF_IRQ_VECTOR) ? {24'h000000, irq_vector_ff} :
    (off == tsr_pkg::OFF_SLOT) ? {27'h0000000, slot_ff} :
    (off == tsr_pkg::OFF_BCAST_BASE) ? {24'h000000, bcast_ff} :
    (off == tsr_pkg::OFF_BCAST_CTL) ? {30'h00000000, bcast_ctl_ff} :
    (off == tsr_pkg::OFF_TRIG_COUNT) ? trig_cnt_ff :
    (off == tsr_pkg::OFF_EVENTS_HELD) ? {16'h0000, acq.events_held} :
    (off == tsr_pkg::OFF_WARN_LEVEL) ? {16'h0000, warn_ff} :
    (off == tsr_pkg::OFF_BLOCK_EVENTS) ? {24'h000000, blt_ff} :
    (off == tsr_pkg::OFF_FW_VERSION) ? {24'h000000, FW_REVISION} : 32'h00000000;

  // ************************************************************
  // Bus answer
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= (base_hit & mapped) | (acc_req & acc_iack & (irq_level_ff != 3'h0));
      if (acc_req & acc_iack) begin
        rdata_ff <= {24'h000000, irq_vector_ff};
      end else if (rd & mapped) begin
        rdata_ff <= rd_mux;
      end else begin
        rdata_ff <= 32'h00000000;
      end
    end
  end

  // ************************************************************
  // Strobes
  // ************************************************************
  // Strobes see only the external reset so a module reset still ends after one cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      strobe_ff <= '0;
    end else begin
      strobe_ff.module_reset <= hit_mod_reset;
      strobe_ff.soft_clear <= w_clear;
      strobe_ff.chip_global_reset <= w_clear;
      strobe_ff.chip_event_reset <= w_evrst;
      strobe_ff.soft_trigger <= w_trig;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      reloc_hi_ff <= 8'h00;
      reloc_lo_ff <= 8'h00;
      reloc_en_ff <= 1'b0;
      irq_level_ff <= tsr_pkg::RST_IRQ_LEVEL;
      irq_vector_ff <= tsr_pkg::RST_IRQ_VECTOR;
      slot_ff <= tsr_pkg::RST_SLOT;
      bcast_ff <= tsr_pkg::RST_BCAST_BASE;
      bcast_ctl_ff <= 2'h0;
      warn_ff <= tsr_pkg::RST_WARN_LEVEL;
      blt_ff <= tsr_pkg::RST_BLOCK_EVENTS;
    end else begin
      if (w_reloc_hi) reloc_hi_ff <= acc_wdata[7:0];
      if (w_reloc_lo) reloc_lo_ff <= acc_wdata[7:0];
      if (w_reloc_en) reloc_en_ff <= acc_wdata[0];
      if (w_level) irq_level_ff <= acc_wdata[2:0];
      if (w_vector) irq_vector_ff <= acc_wdata[7:0];
      if (w_slot) slot_ff <= acc_wdata[4:0];
      if (w_bcast) bcast_ff <= acc_wdata[7:0];
      if (w_bctl) bcast_ctl_ff <= acc_wdata[1:0];
      if (w_warn) warn_ff <= nxt_warn;
      if (w_blt) blt_ff <= acc_wdata[7:0];
    end
  end

  // ************************************************************
  // Sticky flags, counter and status capture
  // ************************************************************
  // Setting wins over a status read in the same cycle so no event is lost
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      berr_ff <= 1'b0;
      trglost_ff <= 1'b0;
      chain_done_ff <= 1'b0;
      trig_cnt_ff <= 32'h00000000;
      status_ff <= 16'h0000;
      irq_ff <= 1'b0;
      term_en_ff <= 1'b0;
    end else begin
      berr_ff <= bus_fault_event | (berr_ff & ~r_status);
      trglost_ff <= trigger_drop_event | (trglost_ff & ~r_status);
      chain_done_ff <= (chain_active & chain_all_sent) | (chain_done_ff & ~chain_end_berr);
      if (strobe_ff.soft_clear) begin
        trig_cnt_ff <= 32'h00000000;
      end else if (acq.window_select_mode & (ext_trigger | strobe_ff.soft_trigger)) begin
        trig_cnt_ff <= trig_cnt_ff + 32'h00000001;
      end
      status_ff <= nxt_status;
      irq_ff <= (irq_level_ff != 3'h0) & almost;
      term_en_ff <= term_on;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign acc_ack = ack_ff;
  assign acc_rdata = rdata_ff;
  assign strobes = strobe_ff;
  assign irq_req = irq_ff;
  assign irq_level = irq_level_ff;
  assign term_enable = term_en_ff;
  assign slot_number = slot_ff;
  assign bcast_base = bcast_ff;
  assign bcast_ctl = bcast_ctl_ff;
  assign buffer_warn_level = warn_ff;
  assign block_event_count = blt_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_status_read;
    r_status & ~bus_fault_event;
  endsequence

  sequence s_clear_write;
    w_clear ##1 strobe_ff.soft_clear;
  endsequence

  property p_full_flag;
    !rst_all |=> (status_ff[tsr_pkg::ST_FULL] == ($past(acq.buf_words) >= 16'h7fdf));
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag wrong");

  property p_almost_flag;
    !rst_all |=> (status_ff[tsr_pkg::ST_ALMOST] == ($past(acq.buf_words) >= $past(warn_ff)));
  endproperty
  a_almost_flag: assert property (p_almost_flag) else $error("almost flag wrong");

  property p_berr_clear;
    s_status_read ##1 !rst_all |-> !berr_ff;
  endproperty
  a_berr_clear: assert property (p_berr_clear) else $error("bus fault flag kept");

  property p_trglost_set;
    trigger_drop_event & !rst_all |=> trglost_ff;
  endproperty
  a_trglost_set: assert property (p_trglost_set) else $error("trigger lost missed");

  property p_irq_off;
    irq_level_ff == 3'h0 |=> !irq_ff;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

  property p_vector;
    acc_req & acc_iack & (irq_level_ff != 3'h0) & !rst_all
      |=> acc_ack && acc_rdata == {24'h000000, $past(irq_vector_ff)};
  endproperty
  a_vector: assert property (p_vector) else $error("vector not returned");

  property p_clear_counter;
    s_clear_write |=> (trig_cnt_ff == 32'h00000000) || rst_all;
  endproperty
  a_clear_counter: assert property (p_clear_counter) else $error("counter not zeroed");

  property p_count_mode;
    !acq.window_select_mode & !strobe_ff.soft_clear & !rst_all |=> $stable(trig_cnt_ff);
  endproperty
  a_count_mode: assert property (p_count_mode) else $error("counted outside mode");

  property p_modrst;
    hit_mod_reset |=> strobe_ff.module_reset ##1 (!strobe_ff.module_reset && slot_ff == 5'h1f);
  endproperty
  a_modrst: assert property (p_modrst) else $error("module reset not single");

  property p_old_base;
    reloc_en_ff & acc_req & !acc_iack & (acc_addr[31:16] != {reloc_hi_ff, reloc_lo_ff})
      |=> !acc_ack;
  endproperty
  a_old_base: assert property (p_old_base) else $error("old base answered");

  property p_wo_read;
    rd & (off == tsr_pkg::OFF_RELOC_EN) |=> acc_rdata == 32'h00000000;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only read not zero");

  property p_clear_strobe;
    w_clear |=> strobe_ff.soft_clear && strobe_ff.chip_global_reset;
  endproperty
  a_clear_strobe: assert property (p_clear_strobe) else $error("clear strobes missing");

  property p_evrst_strobe;
    w_evrst |=> strobe_ff.chip_event_reset;
  endproperty
  a_evrst_strobe: assert property (p_evrst_strobe) else $error("event reset missing");

  // Soft trigger must count exactly like one external trigger
  property p_soft_count;
    w_trig ##1 (acq.window_select_mode & !strobe_ff.soft_clear & !rst_all)
      |=> trig_cnt_ff == $past(trig_cnt_ff) + 32'h00000001;
  endproperty
  a_soft_count: assert property (p_soft_count) else $error("soft trigger not counted");

  property p_level_bits;
    w_level & !rst_all |=> irq_level_ff == $past(acc_wdata[2:0]);
  endproperty
  a_level_bits: assert property (p_level_bits) else $error("level bits wrong");

  property p_irq_on;
    (irq_level_ff != 3'h0) & (acq.buf_words >= warn_ff) & !rst_all |=> irq_ff;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq not raised");

  property p_data_ready;
    !rst_all & acq.window_select_mode & (acq.events_held != 16'h0000)
      |=> status_ff[tsr_pkg::ST_DATA_READY];
  endproperty
  a_data_ready: assert property (p_data_ready) else $error("data ready missed");

  property p_berr_set;
    bus_fault_event & !rst_all |=> berr_ff;
  endproperty
  a_berr_set: assert property (p_berr_set) else $error("bus fault missed");

  property p_purged_empty;
    !rst_all & (acq.buf_words == 16'h0000) |=> status_ff[tsr_pkg::ST_PURGED];
  endproperty
  a_purged_empty: assert property (p_purged_empty) else $error("purged missed");

  property p_mode_bit;
    !rst_all |=> status_ff[tsr_pkg::ST_MODE] == $past(acq.window_select_mode);
  endproperty
  a_mode_bit: assert property (p_mode_bit) else $error("mode bit wrong");

endmodule

`default_nettype wire

// file: verilog/tsr_pkg.sv
// Constants and carrier types of the converter's status and control register bank.
// Assumes one 50 MHz clock and a master that issues one register access at a time.
`default_nettype none

package tsr_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [15:0] OFF_STATUS = 16'h1002;
  localparam logic [15:0] OFF_RELOC_HIGH = 16'h1004;
  localparam logic [15:0] OFF_RELOC_LOW = 16'h1006;
  localparam logic [15:0] OFF_RELOC_EN = 16'h1008;
  localparam logic [15:0] OFF_IRQ_LEVEL = 16'h100a;
  localparam logic [15:0] OFF_IRQ_VECTOR = 16'h100c;
  localparam logic [15:0] OFF_SLOT = 16'h100e;
  localparam logic [15:0] OFF_BCAST_BASE = 16'h1010;
  localparam logic [15:0] OFF_BCAST_CTL = 16'h1012;
  localparam logic [15:0] OFF_MOD_RESET = 16'h1014;
  localparam logic [15:0] OFF_SOFT_CLEAR = 16'h1016;
  localparam logic [15:0] OFF_SOFT_EVRST = 16'h1018;
  localparam logic [15:0] OFF_SOFT_TRIG = 16'h101a;
  localparam logic [15:0] OFF_TRIG_COUNT = 16'h101c;
  localparam logic [15:0] OFF_EVENTS_HELD = 16'h1020;
  localparam logic [15:0] OFF_WARN_LEVEL = 16'h1022;
  localparam logic [15:0] OFF_BLOCK_EVENTS = 16'h1024;
  localparam logic [15:0] OFF_FW_VERSION = 16'h1026;

  // ************************************************************
  // Status field positions
  // ************************************************************
  localparam int ST_DATA_READY = 0;
  localparam int ST_ALMOST = 1;
  localparam int ST_FULL = 2;
  localparam int ST_MODE = 3;
  localparam int ST_HEADER = 4;
  localparam int ST_TERM = 5;
  localparam int ST_ERR0 = 6;
  localparam int ST_BERR = 10;
  localparam int ST_PURGED = 11;
  localparam int ST_RES0 = 12;
  localparam int ST_PAIR = 14;
  localparam int ST_TRGLOST = 15;

  // ************************************************************
  // Reset values and limits
  // ************************************************************
  localparam logic [2:0] RST_IRQ_LEVEL = 3'h0;
  localparam logic [7:0] RST_IRQ_VECTOR = 8'hdd;
  localparam logic [4:0] RST_SLOT = 5'h1f;
  localparam logic [7:0] RST_BCAST_BASE = 8'haa;
  localparam logic [15:0] RST_WARN_LEVEL = 16'h0040;
  localparam logic [7:0] RST_BLOCK_EVENTS = 8'h00;
  localparam logic [15:0] BUF_CAPACITY = 16'h8000;
  localparam logic [15:0] BUF_FULL_MARGIN = 16'h0021;
  localparam logic [15:0] FULL_WORDS = BUF_CAPACITY - BUF_FULL_MARGIN;
  localparam logic [15:0] WARN_MIN = 16'h0001;
  localparam logic [15:0] WARN_MAX = 16'h7fdf;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic [15:0] buf_words;
    logic [15:0] events_held;
    logic window_select_mode;
    logic header_en;
    logic pair_mode;
    logic [1:0] resolution_code;
    logic term_soft_sel;
    logic term_soft_on;
  } tsr_acq_t;

  typedef struct packed {
    logic module_reset;
    logic soft_clear;
    logic chip_global_reset;
    logic chip_event_reset;
    logic soft_trigger;
  } tsr_strobe_t;

endpackage

`default_nettype wire

// file: sim/tsr_master.sv
// Access master model for the register bank, one access at a time.
// Assumes the bench calls xfer; every line changes just after a rising edge.
`default_nettype none

module tsr_master (
  // Clock and answer
  input wire logic sys_clk,
  input wire logic acc_ack,
  // Request
  output logic acc_req,
  output logic acc_write,
  output logic acc_iack,
  output logic [31:0] acc_addr,
  output logic [31:0] acc_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    acc_req = 1'b0;
    acc_write = 1'b0;
    acc_iack = 1'b0;
    acc_addr = 32'h0;
    acc_wdata = 32'h0;
  end

  // ********************************
  // One access
  // ********************************
  // Released lines show the inverse, so a stale value never passes for a held one
  task automatic xfer(input logic wr, input logic ik, input logic [31:0] a,
      input logic [31:0] d, input logic want, output logic late);
    late = want;
    @(posedge sys_clk);
    acc_req <= 1'b1;
    acc_write <= wr;
    acc_iack <= ik;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge sys_clk);
    acc_req <= 1'b0;
    acc_write <= ~wr;
    acc_iack <= ~ik;
    acc_addr <= ~a;
    acc_wdata <= ~d;
    repeat (4) begin
      @(posedge sys_clk);
      if (acc_ack === 1'b1) late = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the status and control register bank.
// Assumes tsr_master drives the access port; the bench drives every other input.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic chk;
    tsr_pkg::tsr_strobe_t stb;
    logic [31:0] val;
  } tsr_exp_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic acc_req, acc_write, acc_iack, acc_ack, irq_req, term_enable;
  logic [31:0] acc_addr, acc_wdata, acc_rdata;
  logic [15:0] rotary_base = 16'h00ee;
  logic term_switch = 1'b0;
  tsr_pkg::tsr_acq_t acq = '0;
  logic [3:0] chip_error = 4'h0;
  logic bus_fault_event = 1'b0, trigger_drop_event = 1'b0, ext_trigger = 1'b0;
  logic chain_active = 1'b0, chain_all_sent = 1'b0, chain_end_berr = 1'b0;
  tsr_pkg::tsr_strobe_t strobes;
  logic [2:0] irq_level;
  logic [4:0] slot_number;
  logic [7:0] bcast_base, block_event_count;
  logic [1:0] bcast_ctl;
  logic [15:0] buffer_warn_level, s, base = 16'h00ee, rnd = 16'h0034, warn = 16'h0040;
  logic chain_pg = 1'b0;
  logic [15:0] offs[6] = '{16'h100a, 16'h100c, 16'h100e, 16'h1010, 16'h1012, 16'h1024};
  logic [15:0] msk[6] = '{16'h7, 16'hff, 16'h1f, 16'hff, 16'h3, 16'hff};
  logic [31:0] wl[4] = '{32'h0, 32'hffff, 32'h7fdf, 32'ha};
  logic [31:0] wx[4] = '{32'h1, 32'h7fdf, 32'h7fdf, 32'ha};
  logic [15:0] bw[6] = '{16'h0, 16'h9, 16'ha, 16'h7fde, 16'h7fdf, 16'h7fff};
  int num_errors = 0, checks = 0, i;
  tsr_exp_t q[$], e;

  always #10 sys_clk = ~sys_clk;

  tsr_master mst (.sys_clk(sys_clk), .acc_ack(acc_ack), .acc_req(acc_req),
    .acc_write(acc_write), .acc_iack(acc_iack), .acc_addr(acc_addr), .acc_wdata(acc_wdata));

  tsr_regs #(.FW_REVISION(8'h3c)) dut (.sys_clk(sys_clk), .reset(reset),
    .acc_req(acc_req), .acc_write(acc_write), .acc_iack(acc_iack), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
    .rotary_base(rotary_base), .term_switch(term_switch), .acq(acq), .chip_error(chip_error),
    .bus_fault_event(bus_fault_event), .trigger_drop_event(trigger_drop_event),
    .ext_trigger(ext_trigger), .chain_active(chain_active), .chain_all_sent(chain_all_sent),
    .chain_end_berr(chain_end_berr), .strobes(strobes), .irq_req(irq_req),
    .irq_level(irq_level), .term_enable(term_enable), .slot_number(slot_number),
    .bcast_base(bcast_base), .bcast_ctl(bcast_ctl), .buffer_warn_level(buffer_warn_level),
    .block_event_count(block_event_count));

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [15:0] st_exp(input logic bf, input logic tl);
    logic [15:0] r;
    r = 16'h0;
    r[0] = acq.window_select_mode ? (acq.events_held != 0) : (acq.buf_words != 0);
    r[1] = acq.buf_words >= warn;
    r[2] = acq.buf_words >= tsr_pkg::FULL_WORDS;
    r[5:3] = {acq.term_soft_sel ? acq.term_soft_on : term_switch, acq.header_en,
      acq.window_select_mode};
    r[9:6] = chip_error;
    r[15:10] = {tl, acq.pair_mode, acq.resolution_code, (acq.buf_words == 0) | chain_pg,
      bf};
    return r;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic ik, input logic [15:0] off,
      input logic [31:0] wd, input logic want, input logic chk, input logic [31:0] ev,
      input tsr_pkg::tsr_strobe_t st);
    logic late;
    if (want) q.push_back('{chk, st, ev});
    mst.xfer(wr, ik, {base, off}, wd, want, late);
    if (late) begin
      num_errors++;
      $display("Error %0t: access not answered", $time);
    end
  endtask

  task automatic wr(input logic [15:0] off, input logic [31:0] wd, input logic [4:0] st);
    acc(1'b1, 1'b0, off, wd, 1'b1, 1'b0, 32'h0, st);
  endtask

  task automatic rd(input logic [15:0] off, input logic [31:0] ev);
    acc(1'b0, 1'b0, off, 32'h0, 1'b1, 1'b1, ev, 5'h0);
  endtask

  task automatic finish_test();
    $display("Checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ********************************
  // Answer monitor
  // ********************************
  always @(posedge sys_clk) begin
    if (acc_ack === 1'b1) begin
      if (q.size() == 0) begin
        num_errors++;
        $display("Error %0t: unexpected answer", $time);
      end else begin
        e = q.pop_front();
        if (e.chk) cmp(acc_rdata, e.val);
        cmp(32'(strobes), 32'(e.stb));
      end
    end
  end

  initial begin
    #1000000;
    num_errors++;
    $display("Error %0t: run hung", $time);
    finish_test();
  end

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    cyc(16);
    reset <= 1'b0;
    rd(16'h100a, 32'h0);
    rd(16'h100c, 32'hdd);
    rd(16'h100e, 32'h1f);
    rd(16'h1010, 32'haa);
    rd(16'h1022, 32'h40);
    rd(16'h1024, 32'h0);
    rd(16'h1008, 32'h0);
    rd(16'h101c, 32'h0);
    rd(16'h1026, 32'h3c);
    cmp(32'(slot_number), 32'h1f);
    cmp(32'(bcast_base), 32'haa);
    for (i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      wr(offs[i % 6], {16'hffff, rnd}, 5'h0);
      rd(offs[i % 6], 32'(rnd & msk[i % 6]));
      if (i % 6 == 4) cmp(32'(bcast_ctl), 32'(rnd & msk[4]));
      if (i % 6 == 5) cmp(32'(block_event_count), 32'(rnd & msk[5]));
    end
    wr(16'h100e, 32'h5, 5'h0);
    cmp(32'(slot_number), 32'h5);
    // Out-of-range levels are clamped, not wrapped
    for (i = 0; i < 4; i++) begin
      wr(16'h1022, wl[i], 5'h0);
      rd(16'h1022, wx[i]);
    end
    warn = 16'ha;
    cmp(32'(buffer_warn_level), 32'ha);
    for (i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      acq <= '{bw[i], {14'h0, rnd[1:0]}, rnd[2], rnd[3], rnd[4], 2'(i % 3), rnd[5], rnd[6]};
      term_switch <= rnd[7];
      chip_error <= rnd[11:8];
      cyc(2);
      s = st_exp(1'b0, 1'b0);
      rd(16'h1002, {16'h0, s});
      rd(16'h1020, 32'(acq.events_held));
      cmp(32'(term_enable), 32'(s[5]));
    end
    bus_fault_event <= 1'b1;
    trigger_drop_event <= 1'b1;
    cyc(1);
    bus_fault_event <= 1'b0;
    trigger_drop_event <= 1'b0;
    rd(16'h1002, {16'h0, st_exp(1'b1, 1'b1)});
    rd(16'h1002, {16'h0, st_exp(1'b0, 1'b0)});
    acq.window_select_mode <= 1'b1;
    wr(16'h1016, 32'h0, 5'h0c);
    for (i = 0; i < 3; i++) wr(16'h101a, 32'h0, 5'h01);
    ext_trigger <= 1'b1;
    cyc(1);
    ext_trigger <= 1'b0;
    wr(16'h101c, 32'h55, 5'h0);
    rd(16'h101c, 32'h4);
    acq.window_select_mode <= 1'b0;
    wr(16'h101a, 32'h0, 5'h01);
    rd(16'h101c, 32'h4);
    wr(16'h1018, 32'h0, 5'h02);
    wr(16'h1016, 32'h0, 5'h0c);
    rd(16'h101c, 32'h0);
    wr(16'h100c, 32'h5a, 5'h0);
    wr(16'h100a, 32'hfffb, 5'h0);
    acq.buf_words <= 16'ha;
    cyc(3);
    cmp(32'(irq_level), 32'h3);
    cmp(32'(irq_req), 32'h1);
    acq.buf_words <= 16'h9;
    cyc(3);
    cmp(32'(irq_req), 32'h0);
    acc(1'b0, 1'b1, 16'h0, 32'h0, 1'b1, 1'b1, 32'h5a, 5'h0);
    wr(16'h100a, 32'h0, 5'h0);
    acc(1'b0, 1'b1, 16'h0, 32'h0, 1'b0, 1'b0, 32'h0, 5'h0);
    wr(16'h1004, 32'h12, 5'h0);
    wr(16'h1006, 32'h34, 5'h0);
    rd(16'h1006, 32'h34);
    wr(16'h1008, 32'h1, 5'h0);
    acc(1'b0, 1'b0, 16'h100a, 32'h0, 1'b0, 1'b0, 32'h0, 5'h0);
    base = 16'h1234;
    rd(16'h100a, 32'h0);
    acc(1'b0, 1'b0, 16'h101e, 32'h0, 1'b0, 1'b0, 32'h0, 5'h0);
    acq.buf_words <= 16'd100;
    chain_active <= 1'b1;
    chain_all_sent <= 1'b1;
    chain_pg = 1'b1;
    cyc(2);
    rd(16'h1002, {16'h0, st_exp(1'b0, 1'b0)});
    chain_end_berr <= 1'b1;
    chain_all_sent <= 1'b0;
    cyc(1);
    chain_end_berr <= 1'b0;
    chain_active <= 1'b0;
    chain_pg = 1'b0;
    cyc(2);
    rd(16'h1002, {16'h0, st_exp(1'b0, 1'b0)});
    acc(1'b0, 1'b0, 16'h1014, 32'h0, 1'b1, 1'b1, 32'h0, 5'h10);
    base = 16'h00ee;
    rd(16'h100c, 32'hdd);
    rd(16'h1022, 32'h40);
    finish_test();
  end
endmodule

`default_nettype wire
